// ### msrb_bank.v
// Register bank of the optical motion sensor
`timescale 1ns/100ps
`default_nettype none
`include "msrb_defs.vh"
// Function
// - All registers are reached only through the serial port using the seven-bit address of each transaction.
// - The identification register returns a fixed eight-bit part code.
// - Address 0x01 returns an eight-bit silicon revision code.
// - Bit 7 of the motion status register is set when motion has accumulated, bits 6 to 0 read zero.
// - Any write to the motion status register clears the flag and both displacements and stores nothing.
// - X displacement at 0x03 is a signed count since the last report and clears when read.
// - Y displacement at 0x04 is a signed count since the last report and clears when read.
// - Surface quality at 0x05 is the upper eight bits of a nine-bit measurement.
// - Writing 0x5A to the soft reset register at 0x3A resets the whole chip like the reset pin.
// - Bit 1 of the control register at 0x0D enters power-down, left only by a pin or soft reset.
// - Reading the burst register streams X, Y, quality, exposure high, low, brightest pixel and pixel total.
module msrb_bank #(
    parameter [7:0] PART_CODE = 8'h5C, // Arbitrary value
    parameter [7:0] REV_CODE = 8'h03 // Arbitrary value
) (
    input wire sys_clk,
    input wire rst_n,
    input wire select_pin_low,
    input wire sclk_in,
    input wire mosi_in,
    output wire miso_out,
    output wire miso_oe_n,
    input wire motion_valid,
    input wire signed [7:0] motion_dx,
    input wire signed [7:0] motion_dy,
    input wire [8:0] quality_meas,
    input wire [15:0] exposure_meas,
    input wire [7:0] pixel_max_meas,
    input wire [7:0] pixel_sum_meas,
    input wire [7:0] pixel_min_meas,
    input wire pixel_ready,
    input wire [6:0] pixel_value,
    output reg pixel_take,
    output reg pixel_rearm,
    output reg [7:0] ctrl_out,
    output reg [7:0] led_drive_out,
    output reg [7:0] low_power_out,
    output wire power_down,
    output wire soft_reset_pulse
);
    // ------------------------------------------------------------
    // Soft reset
    // ------------------------------------------------------------
    wire addr_valid;
    wire [6:0] addr;
    wire is_write;
    wire wr_strobe;
    wire [7:0] wr_data;
    wire byte_done;
    reg [7:0] rd_data;
    reg soft_rst_r;
    reg [1:0] rst_sync_r;
    wire core_rst_n;
    assign soft_reset_pulse = soft_rst_r;
    // Soft reset is pulsed through a resynchroniser so the released reset is glitch free
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'b00;
        end else if (soft_rst_r) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign core_rst_n = rst_sync_r[1];
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_strobe && addr == `MSRB_ADDR_SOFT_RST && wr_data == `MSRB_SOFT_RST_KEY;
        end
    end
    // ------------------------------------------------------------
    // Serial front end
    // ------------------------------------------------------------
    msrb_serial u_serial (
        .sys_clk(sys_clk),
        .rst_n(core_rst_n),
        .select_pin_low(select_pin_low),
        .sclk_in(sclk_in),
        .mosi_in(mosi_in),
        .miso_out(miso_out),
        .miso_oe_n(miso_oe_n),
        .addr_valid(addr_valid),
        .addr(addr),
        .is_write(is_write),
        .wr_strobe(wr_strobe),
        .wr_data(wr_data),
        .byte_done(byte_done),
        .rd_data(rd_data)
    );
    // ------------------------------------------------------------
    // Motion accumulation
    // ------------------------------------------------------------
    reg signed [7:0] dx_r;
    reg signed [7:0] dy_r;
    reg motion_flag_r;
    reg burst_r;
    reg [2:0] burst_idx_r;
    wire rd_start;
    wire clr_motion;
    wire rd_dx;
    wire rd_dy;
    assign rd_start = addr_valid & ~is_write;
    assign clr_motion = wr_strobe && addr == `MSRB_ADDR_MOTION;
    // X and Y clear on the read that fetches them, including the burst path
    assign rd_dx = (rd_start && addr == `MSRB_ADDR_DX) || (rd_start && addr == `MSRB_ADDR_BURST);
    assign rd_dy = (rd_start && addr == `MSRB_ADDR_DY) || (burst_r && byte_done && burst_idx_r == 3'd0);
    function [7:0] sat_add;
        input [7:0] acc;
        input [7:0] inc;
        reg [8:0] s;
        begin
            s = {acc[7], acc} + {inc[7], inc};
            if (s[8] != s[7]) begin
                sat_add = s[8] ? 8'h80 : 8'h7F;
            end else begin
                sat_add = s[7:0];
            end
        end
    endfunction
    // Motion arriving while a read clears the count starts the new count, so nothing is lost
    always @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            dx_r <= 8'h00;
            dy_r <= 8'h00;
            motion_flag_r <= 1'b0;
        end else begin
            if (clr_motion) begin
                // Motion landing in the clearing cycle starts the next count, so set wins
                dx_r <= motion_valid ? motion_dx : 8'h00;
                dy_r <= motion_valid ? motion_dy : 8'h00;
                motion_flag_r <= motion_valid && (motion_dx != 8'h00 || motion_dy != 8'h00);
            end else begin
                if (rd_dx) begin
                    dx_r <= motion_valid ? motion_dx : 8'h00;
                end else if (motion_valid) begin
                    dx_r <= sat_add(dx_r, motion_dx);
                end
                if (rd_dy) begin
                    dy_r <= motion_valid ? motion_dy : 8'h00;
                end else if (motion_valid) begin
                    dy_r <= sat_add(dy_r, motion_dy);
                end
                if (motion_valid && (motion_dx != 8'h00 || motion_dy != 8'h00)) begin
                    motion_flag_r <= 1'b1;
                end else if (rd_dy) begin
                    motion_flag_r <= 1'b0;
                end
            end
        end
    end
    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            ctrl_out <= `MSRB_CTRL_RST;
            led_drive_out <= `MSRB_LED_DRIVE_RST;
            low_power_out <= `MSRB_LOW_POWER_RST;
            pixel_rearm <= 1'b0;
        end else begin
            pixel_rearm <= 1'b0;
            if (wr_strobe) begin
                case (addr)
                    `MSRB_ADDR_CTRL: begin
                        // Power-down sticks; only a reset clears it
                        ctrl_out <= wr_data | {6'h00, ctrl_out[`MSRB_CTRL_PD_BIT], 1'b0};
                    end
                    `MSRB_ADDR_LED_DRIVE: begin
                        led_drive_out <= wr_data;
                    end
                    `MSRB_ADDR_LOW_POWER: begin
                        low_power_out <= wr_data;
                    end
                    `MSRB_ADDR_PIX_CAP: begin
                        pixel_rearm <= 1'b1;
                    end
                    default: begin
                        pixel_rearm <= 1'b0;
                    end
                endcase
            end
        end
    end
    assign power_down = ctrl_out[`MSRB_CTRL_PD_BIT];
    // ------------------------------------------------------------
    // Burst sequencing
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            burst_r <= 1'b0;
            burst_idx_r <= 3'd0;
        end else if (select_pin_low) begin
            burst_r <= 1'b0; // Burst ends only when select is raised
            burst_idx_r <= 3'd0;
        end else if (rd_start && addr == `MSRB_ADDR_BURST) begin
            burst_r <= 1'b1;
            burst_idx_r <= 3'd0;
        end else if (burst_r && byte_done && burst_idx_r != `MSRB_BURST_LEN) begin
            burst_idx_r <= burst_idx_r + 3'd1;
        end
    end
    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    function [7:0] reg_read;
        input [6:0] a;
        input [7:0] vx;
        input [7:0] vy;
        input [7:0] cap;
        begin
            case (a)
                `MSRB_ADDR_PART_ID: reg_read = PART_CODE;
                `MSRB_ADDR_SI_REV: reg_read = REV_CODE;
                `MSRB_ADDR_MOTION: reg_read = {motion_flag_r, 7'h00};
                `MSRB_ADDR_DX: reg_read = vx;
                `MSRB_ADDR_DY: reg_read = vy;
                `MSRB_ADDR_SQUAL: reg_read = quality_meas[8:1];
                `MSRB_ADDR_EXP_HI: reg_read = exposure_meas[15:8];
                `MSRB_ADDR_EXP_LO: reg_read = exposure_meas[7:0];
                `MSRB_ADDR_PIX_MAX: reg_read = pixel_max_meas;
                `MSRB_ADDR_PIX_SUM: reg_read = pixel_sum_meas;
                `MSRB_ADDR_PIX_MIN: reg_read = pixel_min_meas;
                `MSRB_ADDR_PIX_CAP: reg_read = cap;
                `MSRB_ADDR_CTRL: reg_read = ctrl_out;
                `MSRB_ADDR_REV_INV: reg_read = ~REV_CODE;
                `MSRB_ADDR_LOW_POWER: reg_read = low_power_out;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction
    // Burst byte order, after X which is loaded with the address
    function [6:0] burst_addr;
        input [2:0] idx;
        begin
            case (idx)
                3'd0: burst_addr = `MSRB_ADDR_DY;
                3'd1: burst_addr = `MSRB_ADDR_SQUAL;
                3'd2: burst_addr = `MSRB_ADDR_EXP_HI;
                3'd3: burst_addr = `MSRB_ADDR_EXP_LO;
                3'd4: burst_addr = `MSRB_ADDR_PIX_MAX;
                3'd5: burst_addr = `MSRB_ADDR_PIX_SUM;
                default: burst_addr = 7'h7F;
            endcase
        end
    endfunction
    wire [7:0] cap_byte;
    assign cap_byte = {pixel_ready, pixel_value};
    always @* begin
        rd_data = 8'h00;
        pixel_take = 1'b0;
        if (rd_start) begin
            if (addr == `MSRB_ADDR_BURST) begin
                rd_data = dx_r;
            end else begin
                rd_data = reg_read(addr, dx_r, dy_r, cap_byte);
                pixel_take = (addr == `MSRB_ADDR_PIX_CAP) && pixel_ready;
            end
        end else if (burst_r && byte_done) begin
            rd_data = reg_read(burst_addr(burst_idx_r), dx_r, dy_r, cap_byte);
        end
    end
endmodule // msrb_bank
`default_nettype wire

// ### msrb_bank_assertions.sv
// Port checker of the motion sensor register bank
`timescale 1ns/100ps
`default_nettype none
module msrb_bank_assertions (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic select_pin_low,
    input wire logic sclk_in,
    input wire logic miso_out,
    input wire logic miso_oe_n,
    input wire logic pixel_ready,
    input wire logic pixel_take,
    input wire logic pixel_rearm,
    input wire logic [7:0] ctrl_out,
    input wire logic [7:0] led_drive_out,
    input wire logic [7:0] low_power_out,
    input wire logic power_down,
    input wire logic soft_reset_pulse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Cycles since the last soft reset pulse, held at 15
    logic [3:0] since_sr_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            since_sr_r <= 4'hF;
        else if (soft_reset_pulse)
            since_sr_r <= 4'h0;
        else if (since_sr_r != 4'hF)
            since_sr_r <= since_sr_r + 4'h1;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_cfg_cleared;
        (ctrl_out == 8'h00) && (low_power_out == 8'h00) && (led_drive_out == 8'h00);
    endsequence
    sequence s_cfg_moved;
        !$stable(ctrl_out) || !$stable(low_power_out) || !$stable(led_drive_out);
    endsequence
    AST_OE_SELECT: assert property (miso_oe_n == select_pin_low)
        else $error("MISO enable does not follow select");
    AST_MISO_FALL: assert property (($changed(miso_out) && !select_pin_low && $past(select_pin_low) == 1'b0) |-> !sclk_in)
        else $error("MISO changed while SCLK high");
    AST_CFG_QUIET: assert property (s_cfg_moved |-> (!select_pin_low || since_sr_r < 4'h8))
        else $error("Setting changed outside a transaction");
    AST_TAKE_READY: assert property (pixel_take |-> pixel_ready && !select_pin_low)
        else $error("Pixel take without ready pixel or read");
    AST_REARM_ONE: assert property (pixel_rearm |-> !select_pin_low ##1 !pixel_rearm)
        else $error("Rearm pulse malformed");
    AST_SR_ONE: assert property (soft_reset_pulse |-> !select_pin_low ##1 !soft_reset_pulse)
        else $error("Soft reset pulse malformed");
    AST_SR_CLEARS: assert property (soft_reset_pulse |-> ##[1:6] s_cfg_cleared)
        else $error("Soft reset left settings");
    AST_PD_CTRL: assert property (power_down == ctrl_out[1])
        else $error("Power down differs from control bit");
    AST_PD_STICKY: assert property ($fell(power_down) |-> since_sr_r < 4'h8)
        else $error("Power down left without reset");
endmodule // msrb_bank_assertions
bind msrb_bank msrb_bank_assertions chk_i (.sys_clk, .rst_n, .select_pin_low, .sclk_in, .miso_out, .miso_oe_n,
    .pixel_ready, .pixel_take, .pixel_rearm, .ctrl_out, .led_drive_out, .low_power_out, .power_down,
    .soft_reset_pulse);
`default_nettype wire

// ### msrb_bank_test.sv
// Self-checking testbench of the motion sensor register bank
`timescale 1ns/100ps
`default_nettype none
`include "msrb_defs.vh"
module msrb_bank_test;
    // Identity codes are arbitrary
    localparam logic [7:0] PART = 8'hA7;
    localparam logic [7:0] REV = 8'h2C;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic motion_valid = 1'b0;
    logic signed [7:0] motion_dx = 8'h00;
    logic signed [7:0] motion_dy = 8'h00;
    logic [8:0] quality_meas = 9'h1A5;
    logic [15:0] exposure_meas = 16'h1234;
    logic [7:0] pixel_max_meas = 8'h6E;
    logic [7:0] pixel_sum_meas = 8'hC1;
    logic [7:0] pixel_min_meas = 8'h09;
    logic pixel_ready = 1'b0;
    logic [6:0] pixel_value = 7'h35;
    wire select_pin_low, sclk_in, mosi_in, miso_out, miso_oe_n, pixel_take, pixel_rearm, power_down;
    wire soft_reset_pulse;
    wire [7:0] ctrl_out, led_drive_out, low_power_out;
    int n_errors = 0;
    int n_compared = 0;
    // Pulse counters for outputs that stand one cycle only
    int n_take = 0;
    int n_rearm = 0;
    int n_sreset = 0;
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (pixel_take === 1'b1) begin
            n_take++;
        end
        if (pixel_rearm === 1'b1) begin
            n_rearm++;
        end
        if (soft_reset_pulse === 1'b1) begin
            n_sreset++;
        end
    end
    msrb_bank #(.PART_CODE(PART), .REV_CODE(REV)) uut (.sys_clk, .rst_n, .select_pin_low, .sclk_in, .mosi_in,
        .miso_out, .miso_oe_n, .motion_valid, .motion_dx, .motion_dy, .quality_meas, .exposure_meas,
        .pixel_max_meas, .pixel_sum_meas, .pixel_min_meas, .pixel_ready, .pixel_value, .pixel_take,
        .pixel_rearm, .ctrl_out, .led_drive_out, .low_power_out, .power_down, .soft_reset_pulse);
    msrb_host_model host (.sys_clk, .select_pin_low, .sclk_in, .mosi_in, .miso_out);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic mv(input logic [7:0] x, input logic [7:0] y);
        @(posedge sys_clk) motion_valid <= 1'b1;
        motion_dx <= x;
        motion_dy <= y;
        @(posedge sys_clk) motion_valid <= 1'b0;
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ident();
        chk(ctrl_out, `MSRB_CTRL_RST);
        chk(low_power_out, `MSRB_LOW_POWER_RST);
        chk({7'h00, miso_oe_n}, 8'h01);
        rchk(`MSRB_ADDR_PART_ID, PART);
        rchk(`MSRB_ADDR_SI_REV, REV);
        rchk(`MSRB_ADDR_REV_INV, ~REV);
        rchk(`MSRB_ADDR_MOTION, 8'h00);
    endtask
    // Host reads status, then X and Y back to back
    task automatic t_motion();
        mv(8'h05, 8'hFB);
        rchk(`MSRB_ADDR_MOTION, 8'h80);
        rchk(`MSRB_ADDR_DX, 8'h05);
        rchk(`MSRB_ADDR_DY, 8'hFB);
        rchk(`MSRB_ADDR_DX, 8'h00);
        rchk(`MSRB_ADDR_MOTION, 8'h00);
    endtask
    task automatic t_saturate();
        mv(8'h70, 8'h90);
        mv(8'h70, 8'h90);
        rchk(`MSRB_ADDR_MOTION, 8'h80);
        rchk(`MSRB_ADDR_DX, 8'h7F);
        rchk(`MSRB_ADDR_DY, 8'h80);
        mv(8'h10, 8'hF0);
        host.wr(`MSRB_ADDR_MOTION, 8'hFF);
        rchk(`MSRB_ADDR_MOTION, 8'h00);
        rchk(`MSRB_ADDR_DX, 8'h00);
        rchk(`MSRB_ADDR_DY, 8'h00);
    endtask
    task automatic t_reserved();
        rchk(`MSRB_ADDR_SQUAL, 8'hD2);
        rchk(`MSRB_ADDR_PIX_MIN, 8'h09);
        rchk(7'h0C, 8'h00);
        rchk(7'h50, 8'h00);
        host.wr(`MSRB_ADDR_PART_ID, 8'h00);
        host.wr(7'h0C, 8'hFF);
        rchk(`MSRB_ADDR_PART_ID, PART);
        rchk(7'h0C, 8'h00);
    endtask
    task automatic t_cfg();
        host.wr(`MSRB_ADDR_CTRL, 8'h01);
        chk(ctrl_out, 8'h01);
        rchk(`MSRB_ADDR_CTRL, 8'h01);
        host.wr(`MSRB_ADDR_LOW_POWER, 8'hA5);
        chk(low_power_out, 8'hA5);
        rchk(`MSRB_ADDR_LOW_POWER, 8'hA5);
        host.wr(`MSRB_ADDR_LED_DRIVE, 8'h3C);
        chk(led_drive_out, 8'h3C);
        @(posedge sys_clk) pixel_ready <= 1'b1;
        rchk(`MSRB_ADDR_PIX_CAP, 8'hB5);
        chk(8'(n_take), 8'h01);
        host.wr(`MSRB_ADDR_PIX_CAP, 8'h00);
        chk(8'(n_rearm), 8'h01);
    endtask
    task automatic t_burst();
        logic [7:0] d;
        logic [7:0] exp [7] = '{8'h02, 8'hFE, 8'hD2, 8'h12, 8'h34, 8'h6E, 8'hC1};
        mv(8'h02, 8'hFE);
        host.open_frame();
        host.shift_byte({1'b0, `MSRB_ADDR_BURST}, d);
        repeat (6) @(posedge sys_clk);
        for (int k = 0; k < 7; k++) begin
            host.shift_byte(8'h55, d);
            chk(d, exp[k]);
        end
        host.close_frame();
    endtask
    // A wrong key must not reset; the right one also ends power down
    task automatic t_sreset();
        host.wr(`MSRB_ADDR_CTRL, 8'h02);
        chk({7'h00, power_down}, 8'h01);
        host.wr(`MSRB_ADDR_SOFT_RST, 8'hA5);
        chk({7'h00, power_down}, 8'h01);
        chk(8'(n_sreset), 8'h00);
        host.wr(`MSRB_ADDR_SOFT_RST, `MSRB_SOFT_RST_KEY);
        repeat (4) @(posedge sys_clk);
        chk(8'(n_sreset), 8'h01);
        chk({7'h00, power_down}, 8'h00);
        chk(low_power_out, 8'h00);
        chk(led_drive_out, `MSRB_LED_DRIVE_RST);
        rchk(`MSRB_ADDR_CTRL, 8'h00);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_ident();
        t_motion();
        t_saturate();
        t_reserved();
        t_cfg();
        t_burst();
        t_sreset();
        tally_and_finish();
    end
    // About 40 transactions of some 220 cycles each
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish();
    end
endmodule // msrb_bank_test
`default_nettype wire

// ### msrb_defs.vh
// Register map and constants of the motion sensor register bank
`ifndef MSRB_DEFS_VH
`define MSRB_DEFS_VH
`define MSRB_ADDR_PART_ID    7'h00
`define MSRB_ADDR_SI_REV     7'h01
`define MSRB_ADDR_MOTION     7'h02
`define MSRB_ADDR_DX         7'h03
`define MSRB_ADDR_DY         7'h04
`define MSRB_ADDR_SQUAL      7'h05
`define MSRB_ADDR_EXP_HI     7'h06
`define MSRB_ADDR_EXP_LO     7'h07
`define MSRB_ADDR_PIX_MAX    7'h08
`define MSRB_ADDR_PIX_SUM    7'h09
`define MSRB_ADDR_PIX_MIN    7'h0A
`define MSRB_ADDR_PIX_CAP    7'h0B
`define MSRB_ADDR_CTRL       7'h0D
`define MSRB_ADDR_SOFT_RST   7'h3A
`define MSRB_ADDR_REV_INV    7'h3F
`define MSRB_ADDR_LED_DRIVE  7'h40
`define MSRB_ADDR_LOW_POWER  7'h45
`define MSRB_ADDR_BURST      7'h63
`define MSRB_SOFT_RST_KEY    8'h5A
`define MSRB_MOTION_BIT      7
`define MSRB_CTRL_PD_BIT     1
`define MSRB_CAP_VALID_BIT   7
`define MSRB_CTRL_RST        8'h00
`define MSRB_LOW_POWER_RST   8'h00
`define MSRB_LED_DRIVE_RST   8'h00
`define MSRB_BURST_LEN       3'd7
`endif

// ### msrb_host_model.sv
// Serial port master model standing in for the host microcontroller
`timescale 1ns/100ps
`default_nettype none
module msrb_host_model #(
    parameter int HP = 6
) (
    input wire logic sys_clk,
    output logic select_pin_low,
    output logic sclk_in,
    output logic mosi_in,
    input wire logic miso_out
);
    // ----------------------------------------
    // Framing and bit shifting
    // ----------------------------------------
    // SCLK idles high and stands still between frames
    initial begin
        select_pin_low = 1'b1;
        sclk_in = 1'b1;
        mosi_in = 1'b0;
    end
    task automatic open_frame();
        @(posedge sys_clk) select_pin_low <= 1'b0;
        repeat (HP) @(posedge sys_clk);
    endtask
    // MSB first; MOSI set on the fall, MISO taken at the rise
    task automatic shift_byte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            @(posedge sys_clk) sclk_in <= 1'b0;
            mosi_in <= b[i];
            repeat (HP) @(posedge sys_clk);
            r[i] = miso_out;
            sclk_in <= 1'b1;
            repeat (HP - 1) @(posedge sys_clk);
        end
    endtask
    // Released MOSI flips so a stale level is never mistaken for data
    task automatic close_frame();
        repeat (HP) @(posedge sys_clk);
        select_pin_low <= 1'b1;
        mosi_in <= ~mosi_in;
        repeat (2 * HP) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        logic [7:0] j;
        open_frame();
        shift_byte({1'b0, a}, j);
        repeat (HP) @(posedge sys_clk);
        shift_byte(8'h55, d);
        close_frame();
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] j;
        open_frame();
        shift_byte({1'b1, a}, j);
        shift_byte(d, j);
        close_frame();
    endtask
endmodule // msrb_host_model
`default_nettype wire

// ### msrb_serial.v
// Serial port front end: bit shifting, address and data framing
`timescale 1ns/100ps
`default_nettype none
module msrb_serial (
    input wire sys_clk,
    input wire rst_n,
    input wire select_pin_low,
    input wire sclk_in,
    input wire mosi_in,
    output reg miso_out,
    output wire miso_oe_n,
    output reg addr_valid,
    output reg [6:0] addr,
    output reg is_write,
    output reg wr_strobe,
    output reg [7:0] wr_data,
    output reg byte_done,
    input wire [7:0] rd_data
);
    reg sclk_d_r;
    reg [2:0] bit_cnt_r;
    reg phase_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    wire active;
    wire rise;
    wire fall;
    assign active = ~select_pin_low;
    assign rise = active & sclk_in & ~sclk_d_r;
    assign fall = active & ~sclk_in & sclk_d_r;
    // Output floats while deselected so the port can be shared
    assign miso_oe_n = select_pin_low;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b1;
            bit_cnt_r <= 3'd0;
            phase_r <= 1'b0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            miso_out <= 1'b0;
            addr_valid <= 1'b0;
            addr <= 7'h00;
            is_write <= 1'b0;
            wr_strobe <= 1'b0;
            wr_data <= 8'h00;
            byte_done <= 1'b0;
        end else begin
            sclk_d_r <= sclk_in;
            addr_valid <= 1'b0;
            wr_strobe <= 1'b0;
            byte_done <= 1'b0;
            if (select_pin_low) begin
                // Raising select aborts any transaction in flight
                bit_cnt_r <= 3'd0;
                phase_r <= 1'b0;
            end else if (rise) begin
                shift_r <= {shift_r[6:0], mosi_in};
                bit_cnt_r <= bit_cnt_r + 3'd1;
                if (bit_cnt_r == 3'd7) begin
                    if (!phase_r) begin
                        addr <= {shift_r[5:0], mosi_in};
                        is_write <= shift_r[6];
                        addr_valid <= 1'b1;
                        phase_r <= 1'b1;
                    end else if (is_write) begin
                        wr_data <= {shift_r[6:0], mosi_in};
                        wr_strobe <= 1'b1;
                        phase_r <= 1'b0;
                    end else begin
                        byte_done <= 1'b1;
                    end
                end
            end else if (fall) begin
                miso_out <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
            if (addr_valid || byte_done) begin
                tx_r <= rd_data;
            end
        end
    end
endmodule // msrb_serial
`default_nettype wire
